// ==== pkg/pacc_pkg.sv ====
// Purpose: shared constants and types of the power accumulator register set
// Assumes: 250 MHz system clock, four channels
// Notes: command codes double as register offsets
package pacc_pkg;
  localparam logic [7:0] CMD_SNAPSHOT = 8'h00;
  localparam logic [7:0] CMD_CONFIG = 8'h01;
  localparam logic [7:0] CMD_TALLY = 8'h02;
  localparam logic [7:0] CMD_SUM_CH1 = 8'h03;
  localparam logic [7:0] CMD_SUM_CH4 = 8'h06;
  localparam logic [7:0] READ_INVALID = 8'hff;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [6:0] SLAVE_ADDR_DEFAULT = 7'h20;

  localparam int CFG_SINGLE_BIT = 5;
  localparam int CFG_HOLD_BIT = 4;
  localparam int CFG_SEL_HI_BIT = 3;
  localparam int CFG_SEL_LO_BIT = 2;
  localparam int CFG_SLOW_BIT = 1;
  localparam int CFG_SAT_BIT = 0;

  localparam int NUM_CH = 4;
  localparam int CUR_W = 16;
  localparam int VOLT_W = 12;
  localparam int PROD_W = 28;
  localparam int SUM_W = 48;
  localparam int TALLY_W = 24;
  localparam logic [2:0] SUM_BYTES = 3'd6;
  localparam logic [2:0] TALLY_BYTES = 3'd3;
  localparam logic [2:0] SINGLE_PASS_SAMPLES = 3'd4;

  localparam int CLK_HZ = 250_000_000;
  localparam int UPDATES_PER_SEC = 1024;
  // One sample slot per channel per update period
  localparam int SAMPLE_CYCLES = CLK_HZ / (UPDATES_PER_SEC * NUM_CH);
  localparam int SLOW_FACTOR = 4;
  localparam int TICK_W = 24;

  typedef struct packed {
    logic [CUR_W-1:0] current;
    logic [VOLT_W-1:0] voltage;
  } sample_s;

  typedef struct packed {
    logic single_en;
    logic hold_en;
    logic [1:0] held_channel_sel;
    logic slow_en;
  } config_s;

  typedef struct packed {
    logic start;
    logic stop;
    logic cmd;
    logic wr;
    logic rd;
  } bus_ev_s;
endpackage

// ==== verilog/sat_accum.sv ====
// Purpose: saturating accumulator with clear that keeps a coincident add
// Assumes: addend no wider than the accumulator
// Notes: sat is high while the value is all ones
`timescale 1ns/1ns
module sat_accum #(
  parameter int W = 48,
  parameter int AW = 28
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic clear,
  input wire logic add,
  input wire logic [AW-1:0] addend,
  output logic [W-1:0] value_r,
  output logic sat
);
  logic [W:0] sum;

  assign sum = {1'b0, value_r} + (W+1)'(addend);
  assign sat = &value_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      value_r <= '0;
    end else if (clear) begin
      // A sample landing on the clear starts the new period
      value_r <= add ? W'(addend) : '0;
    end else if (add) begin
      value_r <= sum[W] ? '1 : sum[W-1:0];
    end
  end
endmodule

// ==== verilog/smbus_target.sv ====
// Purpose: SMBus target framing: address, command, write and read bytes
// Assumes: SCL and SDA are asynchronous pins, sampled on sys_clk
// Notes: bytes go out MSB first; rd_byte is taken on the ev.rd pulse
`timescale 1ns/1ns
module smbus_target (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic [6:0] slave_addr,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic cmd_ok,
  input wire logic [7:0] rd_byte,
  output logic [7:0] rx_byte_r,
  output pacc_pkg::bus_ev_s ev
);
  typedef enum logic [3:0] {
    ST_IDLE, ST_ADDR, ST_ACK_ADDR, ST_CMD, ST_ACK_CMD,
    ST_WDATA, ST_ACK_WR, ST_TX, ST_TX_ACK
  } tgt_state_e;

  tgt_state_e state_r;
  logic [1:0] scl_sync_r;
  logic [1:0] sda_sync_r;
  logic scl_d_r;
  logic sda_d_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic [3:0] bit_cnt_r;
  logic is_read_r;
  logic host_ack_r;
  logic [7:0] tx_sh_r;
  logic drive_low_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      scl_sync_r <= 2'b11;
      sda_sync_r <= 2'b11;
      scl_d_r <= 1'b1;
      sda_d_r <= 1'b1;
    end else begin
      scl_sync_r <= {scl_sync_r[0], scl_in};
      sda_sync_r <= {sda_sync_r[0], sda_in};
      scl_d_r <= scl_sync_r[1];
      sda_d_r <= sda_sync_r[1];
    end
  end

  assign scl_rise = scl_sync_r[1] & ~scl_d_r;
  assign scl_fall = ~scl_sync_r[1] & scl_d_r;
  assign start_det = scl_sync_r[1] & scl_d_r & sda_d_r & ~sda_sync_r[1];
  assign stop_det = scl_sync_r[1] & scl_d_r & ~sda_d_r & sda_sync_r[1];
  assign sda_out = 1'b0;
  assign sda_oe_n = ~drive_low_r;

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      state_r <= ST_IDLE;
      bit_cnt_r <= 4'd0;
      rx_byte_r <= 8'h00;
      tx_sh_r <= 8'h00;
      is_read_r <= 1'b0;
      host_ack_r <= 1'b0;
      drive_low_r <= 1'b0;
      ev <= '0;
    end else begin
      ev <= '0;
      if (start_det) begin
        state_r <= ST_ADDR;
        bit_cnt_r <= 4'd0;
        drive_low_r <= 1'b0;
        ev.start <= 1'b1;
      end else if (stop_det) begin
        state_r <= ST_IDLE;
        drive_low_r <= 1'b0;
        ev.stop <= 1'b1;
      end else begin
        case (state_r)
          ST_ADDR, ST_CMD, ST_WDATA: begin
            if (scl_rise) begin
              rx_byte_r <= {rx_byte_r[6:0], sda_sync_r[1]};
              bit_cnt_r <= bit_cnt_r + 4'd1;
            end else if (scl_fall && bit_cnt_r == 4'd8) begin
              bit_cnt_r <= 4'd0;
              if (state_r == ST_ADDR) begin
                if (rx_byte_r[7:1] == slave_addr) begin
                  state_r <= ST_ACK_ADDR;
                  is_read_r <= rx_byte_r[0];
                  drive_low_r <= 1'b1;
                end else begin
                  state_r <= ST_IDLE;
                end
              end else if (state_r == ST_CMD) begin
                ev.cmd <= 1'b1;
                state_r <= cmd_ok ? ST_ACK_CMD : ST_IDLE;
                drive_low_r <= cmd_ok;
              end else begin
                ev.wr <= 1'b1;
                state_r <= ST_ACK_WR;
                drive_low_r <= 1'b1;
              end
            end
          end
          ST_ACK_ADDR: begin
            if (scl_fall) begin
              if (is_read_r) begin
                state_r <= ST_TX;
                ev.rd <= 1'b1;
                tx_sh_r <= {rd_byte[6:0], 1'b0};
                drive_low_r <= ~rd_byte[7];
              end else begin
                state_r <= ST_CMD;
                drive_low_r <= 1'b0;
              end
            end
          end
          ST_ACK_CMD, ST_ACK_WR: begin
            if (scl_fall) begin
              state_r <= ST_WDATA;
              drive_low_r <= 1'b0;
            end
          end
          ST_TX: begin
            if (scl_rise) begin
              bit_cnt_r <= bit_cnt_r + 4'd1;
            end else if (scl_fall) begin
              if (bit_cnt_r == 4'd8) begin
                state_r <= ST_TX_ACK;
                bit_cnt_r <= 4'd0;
                drive_low_r <= 1'b0;
              end else begin
                drive_low_r <= ~tx_sh_r[7];
                tx_sh_r <= {tx_sh_r[6:0], 1'b0};
              end
            end
          end
          ST_TX_ACK: begin
            if (scl_rise) begin
              host_ack_r <= ~sda_sync_r[1];
            end else if (scl_fall) begin
              if (host_ack_r) begin
                state_r <= ST_TX;
                ev.rd <= 1'b1;
                tx_sh_r <= {rd_byte[6:0], 1'b0};
                drive_low_r <= ~rd_byte[7];
              end else begin
                state_r <= ST_IDLE;
              end
            end
          end
          default: begin
            state_r <= ST_IDLE;
          end
        endcase
      end
    end
  end
endmodule

// ==== verilog/power_accum_regs.sv ====
// Purpose: command-addressed registers and accumulation of four channels
// Assumes: samples arrive on sys_clk for the channel named by sample_ch
// Notes: snapshot copies sums and tally and restarts accumulation
`timescale 1ns/1ns

module power_accum_regs #(
  parameter int SAMPLE_CYCLES = pacc_pkg::SAMPLE_CYCLES,
  parameter logic [6:0] SLAVE_ADDR = pacc_pkg::SLAVE_ADDR_DEFAULT
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe_n,
  input wire logic slow_pin,
  input pacc_pkg::sample_s sample,
  output logic [1:0] sample_ch,
  output logic sample_take
);
  pacc_pkg::config_s cfg_r;
  pacc_pkg::bus_ev_s ev;
  logic saturation_flag_r;
  logic [7:0] rx_byte;
  logic [7:0] rd_byte;
  logic [7:0] cmd_r;
  logic [2:0] idx_r;
  logic pend_snap_r;
  logic snapshot;
  logic [1:0] slow_sync_r;
  logic slow_any;
  logic [pacc_pkg::TICK_W-1:0] tick_cnt_r;
  logic [pacc_pkg::TICK_W-1:0] tick_last;
  logic tick;
  logic [2:0] pass_left_r;
  logic [1:0] rr_ch_r;
  logic accum_add;
  logic [pacc_pkg::PROD_W-1:0] product;
  logic [pacc_pkg::SUM_W-1:0] sum_live [pacc_pkg::NUM_CH];
  logic [pacc_pkg::SUM_W-1:0] snap_sum_r [pacc_pkg::NUM_CH];
  logic [pacc_pkg::NUM_CH-1:0] sum_sat;
  logic [pacc_pkg::TALLY_W-1:0] tally_live;
  logic [pacc_pkg::TALLY_W-1:0] snap_tally_r;
  logic tally_sat;
  logic any_sat;
  logic cfg_wr;
  logic [7:0] cfg_byte;

  // Codes 00h..06h are served here; everything else is refused
  function automatic logic cmd_known(input logic [7:0] c);
    cmd_known = (c <= pacc_pkg::CMD_SUM_CH4);
  endfunction

  // Byte idx of a block read: count first, then data MSB first
  function automatic logic [7:0] pick_byte(
    input logic [pacc_pkg::SUM_W-1:0] v,
    input logic [2:0] n,
    input logic [2:0] idx
  );
    logic [5:0] base;
    base = 6'd0;
    if (idx == 3'd0) begin
      pick_byte = {5'd0, n};
    end else if (idx > n) begin
      pick_byte = pacc_pkg::READ_INVALID;
    end else begin
      base = {3'd0, n - idx} << 3;
      pick_byte = v[base +: 8];
    end
  endfunction

  smbus_target u_target (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .slave_addr(SLAVE_ADDR),
    .scl_in(scl_in),
    .sda_in(sda_in),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .cmd_ok(cmd_known(rx_byte)),
    .rd_byte(rd_byte),
    .rx_byte_r(rx_byte),
    .ev(ev)
  );

  // send-byte snapshot detect
  // Any data byte or restart cancels it, so only a bare send-byte counts
  // Dropped at the stop too, so a stray second stop cannot fire it again
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pend_snap_r <= 1'b0;
    end else if (ev.start || ev.wr || ev.stop) begin
      pend_snap_r <= 1'b0;
    end else if (ev.cmd) begin
      pend_snap_r <= (rx_byte == pacc_pkg::CMD_SNAPSHOT);
    end
  end

  assign snapshot = ev.stop & pend_snap_r;

  // Command pointer defaults to the configuration register
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cmd_r <= pacc_pkg::CMD_CONFIG;
    end else if (ev.cmd) begin
      cmd_r <= rx_byte;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      idx_r <= 3'd0;
    end else if (ev.start) begin
      idx_r <= 3'd0;
    end else if (ev.rd && idx_r != 3'd7) begin
      idx_r <= idx_r + 3'd1;
    end
  end

  assign cfg_byte = {2'b00, cfg_r.single_en, cfg_r.hold_en,
                     cfg_r.held_channel_sel, cfg_r.slow_en,
                     saturation_flag_r};

  always_comb begin
    if (!cmd_known(cmd_r) || cmd_r == pacc_pkg::CMD_SNAPSHOT) begin
      rd_byte = pacc_pkg::READ_INVALID;
    end else if (cmd_r == pacc_pkg::CMD_CONFIG) begin
      rd_byte = (idx_r == 3'd0) ? cfg_byte : pacc_pkg::READ_INVALID;
    end else if (cmd_r == pacc_pkg::CMD_TALLY) begin
      rd_byte = pick_byte(pacc_pkg::SUM_W'(snap_tally_r),
                          pacc_pkg::TALLY_BYTES, idx_r);
    end else begin
      rd_byte = pick_byte(snap_sum_r[2'(cmd_r - pacc_pkg::CMD_SUM_CH1)],
                          pacc_pkg::SUM_BYTES, idx_r);
    end
  end

  assign cfg_wr = ev.wr & (cmd_r == pacc_pkg::CMD_CONFIG);

  // configuration write
  // Bits 7 and 6 are not stored and always read back as zero
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      cfg_r <= '0;
    end else if (cfg_wr) begin
      cfg_r.single_en <= rx_byte[pacc_pkg::CFG_SINGLE_BIT];
      cfg_r.hold_en <= rx_byte[pacc_pkg::CFG_HOLD_BIT];
      cfg_r.held_channel_sel <=
        rx_byte[pacc_pkg::CFG_SEL_HI_BIT:pacc_pkg::CFG_SEL_LO_BIT];
      cfg_r.slow_en <= rx_byte[pacc_pkg::CFG_SLOW_BIT];
    end
  end

  assign any_sat = (|sum_sat) | tally_sat;

  // clear by snapshot or zero write, saturation wins over the write only
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      saturation_flag_r <= pacc_pkg::CONFIG_RESET[pacc_pkg::CFG_SAT_BIT];
    end else if (snapshot) begin
      saturation_flag_r <= 1'b0;
    end else if (any_sat) begin
      saturation_flag_r <= 1'b1;
    end else if (cfg_wr && !rx_byte[pacc_pkg::CFG_SAT_BIT]) begin
      saturation_flag_r <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      slow_sync_r <= 2'b00;
    end else begin
      slow_sync_r <= {slow_sync_r[0], slow_pin};
    end
  end

  assign slow_any = cfg_r.slow_en | slow_sync_r[1];
  assign tick_last = slow_any ?
    pacc_pkg::TICK_W'(SAMPLE_CYCLES * pacc_pkg::SLOW_FACTOR - 1) :
    pacc_pkg::TICK_W'(SAMPLE_CYCLES - 1);
  assign tick = (tick_cnt_r >= tick_last);

  // one slot per channel turn, 1024 per second each with hold_en clear, 256 while slow_any is set
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      tick_cnt_r <= '0;
    end else if (tick) begin
      tick_cnt_r <= '0;
    end else begin
      tick_cnt_r <= tick_cnt_r + 1'b1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      pass_left_r <= 3'd0;
    end else if (snapshot) begin
      pass_left_r <= cfg_r.single_en ? pacc_pkg::SINGLE_PASS_SAMPLES : 3'd0;
    end else if (sample_take && pass_left_r != 3'd0) begin
      pass_left_r <= pass_left_r - 3'd1;
    end
  end

  // A slot that lands on a single-measure snapshot is skipped so the
  // new pass holds exactly four samples
  assign sample_take = tick & (~cfg_r.single_en | (pass_left_r != 3'd0))
                     & ~(snapshot & cfg_r.single_en);

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      rr_ch_r <= 2'd0;
    end else if (snapshot && cfg_r.single_en) begin
      rr_ch_r <= 2'd0;
    end else if (sample_take && !cfg_r.hold_en) begin
      rr_ch_r <= rr_ch_r + 2'd1;
    end
  end

  assign sample_ch = cfg_r.hold_en ? cfg_r.held_channel_sel : rr_ch_r;

  assign product = pacc_pkg::PROD_W'(sample.current) *
                   pacc_pkg::PROD_W'(sample.voltage);
  assign accum_add = sample_take;

  for (genvar ch = 0; ch < pacc_pkg::NUM_CH; ch++) begin : g_ch
    sat_accum #(.W(pacc_pkg::SUM_W), .AW(pacc_pkg::PROD_W)) u_sum (
      .clk(sys_clk),
      .rst(sys_rst),
      .clear(snapshot),
      .add(accum_add && sample_ch == 2'(ch)),
      .addend(product),
      .value_r(sum_live[ch]),
      .sat(sum_sat[ch])
    );
  end

  sat_accum #(.W(pacc_pkg::TALLY_W), .AW(1)) u_tally (
    .clk(sys_clk),
    .rst(sys_rst),
    .clear(snapshot),
    .add(accum_add),
    .addend(1'b1),
    .value_r(tally_live),
    .sat(tally_sat)
  );

  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      snap_tally_r <= '0;
      for (int i = 0; i < pacc_pkg::NUM_CH; i++) begin
        snap_sum_r[i] <= '0;
      end
    end else if (snapshot) begin
      snap_tally_r <= tally_live;
      for (int i = 0; i < pacc_pkg::NUM_CH; i++) begin
        snap_sum_r[i] <= sum_live[i];
      end
    end
  end
endmodule

// ==== tb/power_accum_regs_asserts.sv ====
// Purpose: port checks of the power accumulator register block
// Assumes: host holds SCL low at least 8 sys_clk and high at most 8 in frames
// Notes: bound to every power_accum_regs instance
`timescale 1ns/1ns
module power_accum_regs_asserts #(
  parameter int SAMPLE_CYCLES = pacc_pkg::SAMPLE_CYCLES
) (
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic scl_in,
  input wire logic sda_out,
  input wire logic sda_oe_n,
  input wire logic slow_pin,
  input wire logic [1:0] sample_ch,
  input wire logic sample_take
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (sys_rst);

  int gap_r;
  int slow_hi_r;
  logic [3:0] scl_hi_r;

  // Saturating, so a long quiet spell never wraps to a small gap
  always_ff @(posedge sys_clk) begin
    if (sys_rst) begin
      gap_r <= 8 * SAMPLE_CYCLES;
    end else if (sample_take) begin
      gap_r <= 1;
    end else if (gap_r < 8 * SAMPLE_CYCLES) begin
      gap_r <= gap_r + 1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !slow_pin) begin
      slow_hi_r <= 0;
    end else if (slow_hi_r < 16 * SAMPLE_CYCLES) begin
      slow_hi_r <= slow_hi_r + 1;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (sys_rst || !scl_in) begin
      scl_hi_r <= 4'h0;
    end else if (scl_hi_r < 4'hf) begin
      scl_hi_r <= scl_hi_r + 4'h1;
    end
  end

  AST_TAKE_PULSE: assert property (
    sample_take |=> !sample_take [*8])
    else $error("sample take lasted more than one cycle");
  AST_TAKE_SPACING: assert property (
    sample_take |-> gap_r >= SAMPLE_CYCLES)
    else $error("samples taken closer than one slot");
  AST_SLOW_SPACING: assert property (
    sample_take && slow_hi_r > 8 * SAMPLE_CYCLES |->
      gap_r >= 4 * SAMPLE_CYCLES)
    else $error("slow pin did not slow accumulation");
  AST_SDA_OPEN_DRAIN: assert property (
    !sda_oe_n |-> sda_out == 1'b0)
    else $error("data line driven high");
  AST_SDA_SCL_LOW: assert property (
    $changed(sda_oe_n) |-> !scl_in && !$past(scl_in))
    else $error("data line moved while clock high");
  AST_IDLE_RELEASE: assert property (
    scl_hi_r >= 4'hc |-> sda_oe_n)
    else $error("data line held outside a bit");
  AST_RESET_STATE: assert property (
    $fell(sys_rst) |-> sda_oe_n && sample_ch == 2'h0 && !sample_take)
    else $error("outputs not at reset state");
  AST_RESET_QUIET: assert property (
    $fell(sys_rst) |-> !sample_take [*8])
    else $error("sample taken right after reset");
endmodule

bind power_accum_regs power_accum_regs_asserts #(
  .SAMPLE_CYCLES(SAMPLE_CYCLES)
) u_asserts (
  .sys_clk(sys_clk),
  .sys_rst(sys_rst),
  .scl_in(scl_in),
  .sda_out(sda_out),
  .sda_oe_n(sda_oe_n),
  .slow_pin(slow_pin),
  .sample_ch(sample_ch),
  .sample_take(sample_take)
);

// ==== tb/smbus_host_model.sv ====
// Purpose: SMBus host controller model for the register block
// Assumes: bit period of 16 sys_clk (64 ns), pins move at falling edges
// Notes: a one is sent by releasing SDA to the pull-up
`timescale 1ns/1ns
module smbus_host_model #(
  parameter logic [6:0] ADDR = 7'h20,
  parameter int SETTLE = 125000
) (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda
);
  logic [7:0] rbuf [0:7];
  time snap_time;

  // SCL stands high between frames
  initial begin
    scl = 1'b1;
    sda = 1'b1;
    snap_time = 0;
  end

  task automatic q(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  task automatic bit_io(input logic b, output logic seen);
    sda = b;
    q(4);
    scl = 1'b1;
    q(4);
    seen = sda_line;
    q(4);
    scl = 1'b0;
    q(4);
  endtask

  task automatic start_c();
    sda = 1'b1;
    q(4);
    scl = 1'b1;
    q(4);
    sda = 1'b0;
    q(4);
    scl = 1'b0;
    q(4);
  endtask

  task automatic stop_c();
    sda = 1'b0;
    q(4);
    scl = 1'b1;
    q(4);
    sda = 1'b1;
    q(8);
  endtask

  task automatic byte_tx(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], s);
    end
    bit_io(1'b1, ack);
  endtask

  task automatic byte_rx(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, d[i]);
    end
    bit_io(last, s);
  endtask

  task automatic send(input logic [7:0] cmd, input logic has_d,
                      input logic [7:0] d, output logic cmd_ack);
    logic a;
    start_c();
    byte_tx({ADDR, 1'b0}, a);
    byte_tx(cmd, cmd_ack);
    if (has_d) begin
      byte_tx(d, a);
    end
    stop_c();
  endtask

  // Host NACKs the last byte it wants, then stops
  task automatic read(input logic [7:0] cmd, input int n,
                      output logic cmd_ack);
    logic a;
    start_c();
    byte_tx({ADDR, 1'b0}, a);
    byte_tx(cmd, cmd_ack);
    start_c();
    byte_tx({ADDR, 1'b1}, a);
    for (int i = 0; i < n; i++) begin
      byte_rx(i == n - 1, rbuf[i]);
    end
    stop_c();
  endtask

  task automatic snap();
    logic a;
    send(8'h00, 1'b0, 8'h00, a);
    snap_time = $time;
    q(SETTLE);
  endtask
endmodule

// ==== tb/power_accum_regs_tb.sv ====
// Purpose: self-checking bench of the power accumulator register block
// Assumes: sample source answers at once for the channel asked
// Notes: sample slot and host settle time are shortened for run length
`timescale 1ns/1ns
module power_accum_regs_tb;
  localparam int SC = 25;
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic slow_pin = 1'b0;
  logic scl_h;
  logic sda_h;
  logic sda_line;
  logic sda_out;
  logic sda_oe_n;
  logic [1:0] sample_ch;
  logic sample_take;
  pacc_pkg::sample_s sample = '0;
  logic [15:0] cur [0:3] = '{16'hffff, 16'h1234, 16'h0001, 16'h8000};
  logic [11:0] volt [0:3] = '{12'hfff, 12'habc, 12'h001, 12'h800};
  int n_errors = 0;
  int checks_done = 0;

  assign sda_line = sda_h & (sda_oe_n | sda_out);
  always #2 sys_clk = ~sys_clk;
  always @(negedge sys_clk) sample <= {cur[sample_ch], volt[sample_ch]};

  power_accum_regs #(.SAMPLE_CYCLES(SC), .SLAVE_ADDR(7'h20)) dut (
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .scl_in(scl_h),
    .sda_in(sda_line),
    .sda_out(sda_out),
    .sda_oe_n(sda_oe_n),
    .slow_pin(slow_pin),
    .sample(sample),
    .sample_ch(sample_ch),
    .sample_take(sample_take)
  );

  // The block itself is ready a few cycles after the stop
  smbus_host_model #(.ADDR(7'h20), .SETTLE(200)) host (
    .sys_clk(sys_clk),
    .sda_line(sda_line),
    .scl(scl_h),
    .sda(sda_h)
  );

  function automatic logic [47:0] prod(input int k);
    return 48'(cur[k]) * 48'(volt[k]);
  endfunction

  task automatic conclude();
    $display("checks %0d, mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [47:0] seen,
                       input logic [47:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s: expected %h, seen %h", what, exp, seen);
    end
  endtask

  task automatic rd_block(input logic [7:0] cmd, input int n,
                          output logic [47:0] v);
    logic a;
    host.read(cmd, n + 1, a);
    check("byte count", 48'(host.rbuf[0]), 48'(n));
    v = '0;
    for (int i = 1; i <= n; i++) begin
      v = {v[39:0], host.rbuf[i]};
    end
  endtask

  task automatic wr_cfg(input logic [7:0] cfg);
    logic a;
    host.send(8'h01, 1'b1, cfg, a);
    host.snap();
  endtask

  task automatic t_reset();
    logic [47:0] v;
    logic a;
    host.read(8'h01, 1, a);
    check("config reset", 48'(host.rbuf[0]), 48'h0);
    rd_block(8'h02, 3, v);
    check("tally reset", v, 48'h0);
    rd_block(8'h06, 6, v);
    check("sum reset", v, 48'h0);
  endtask

  task automatic t_config();
    logic a;
    host.send(8'h01, 1'b1, 8'h3f, a);
    host.read(8'h01, 1, a);
    check("config rw", 48'(host.rbuf[0]), 48'h3e);
    host.send(8'h07, 1'b1, 8'h55, a);
    check("unknown code ack", 48'(a), 48'h1);
    host.read(8'h07, 1, a);
    check("unknown code read", 48'(host.rbuf[0]), 48'hff);
    wr_cfg(8'h00);
  endtask

  task automatic t_single_rr();
    logic [47:0] v;
    logic a;
    wr_cfg(8'h20);
    repeat (6 * SC) @(negedge sys_clk);
    host.snap();
    rd_block(8'h02, 3, v);
    check("single tally", v, 48'h4);
    for (int k = 0; k < 4; k++) begin
      rd_block(8'h03 + 8'(k), 6, v);
      check("single sum", v, prod(k));
    end
    host.send(8'h03, 1'b1, 8'h00, a);
    rd_block(8'h03, 6, v);
    check("sum kept", v, prod(0));
  endtask

  task automatic t_hold();
    logic [47:0] v;
    for (int s = 0; s < 4; s++) begin
      wr_cfg(8'h30 | 8'(s << 2));
      repeat (6 * SC) @(negedge sys_clk);
      host.snap();
      rd_block(8'h02, 3, v);
      check("hold tally", v, 48'h4);
      rd_block(8'h03 + 8'(s), 6, v);
      check("held sum", v, prod(s) << 2);
      rd_block(8'h03 + 8'((s + 1) % 4), 6, v);
      check("idle sum", v, 48'h0);
    end
  endtask

  task automatic t_rate(input logic [7:0] cfg, input logic pin, input int m);
    logic [47:0] v;
    logic [47:0] w;
    time t1;
    int e;
    logic ok;
    logic a;
    slow_pin = pin;
    wr_cfg(cfg);
    t1 = host.snap_time;
    repeat (40 * SC) @(negedge sys_clk);
    host.snap();
    rd_block(8'h02, 3, v);
    e = int'((host.snap_time - t1) / 4) / (SC * m);
    ok = (v + 1 >= e) && (v <= e + 1);
    check("tally rate", 48'(ok), 48'h1);
    // A data byte after code 00h must not take a snapshot
    host.send(8'h00, 1'b1, 8'h00, a);
    rd_block(8'h02, 3, w);
    check("no snapshot", w, v);
    slow_pin = 1'b0;
  endtask

  initial begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    repeat (4) @(negedge sys_clk);
    t_reset();
    t_config();
    t_single_rr();
    t_hold();
    t_rate(8'h00, 1'b0, 1);
    t_rate(8'h02, 1'b0, 4);
    t_rate(8'h00, 1'b1, 4);
    conclude();
  end

  // Whole sequence needs about 55000 cycles
  initial begin
    repeat (95000) @(posedge sys_clk);
    n_errors++;
    $display("watchdog expired");
    conclude();
  end
endmodule
